/* include/dsc_pkg.sv */
// constants, types and helper functions shared by the converter control logic
package dsc_pkg;

    // ==========================================================
    // word format
    localparam int DATA_W = 16;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h_f;

    // ==========================================================
    // reset codes and format conversion
    localparam logic [DATA_W-1:0] RESET_CODE_HIGH = 16'h_8000;
    localparam logic [DATA_W-1:0] RESET_CODE_LOW = 16'h_0000;
    localparam logic [DATA_W-1:0] TWOS_FLIP_MASK = 16'h_8000;

    // ==========================================================
    // synchroniser bit positions for the pin inputs
    localparam int PIN_W = 7;
    localparam int PIN_RST_CODE = 0;
    localparam int PIN_FORMAT = 1;
    localparam int PIN_READBACK = 2;
    localparam int PIN_PWR_DOWN = 3;
    localparam int PIN_LOAD_N = 4;
    localparam int PIN_CS_N = 5;
    localparam int PIN_HW_RST_N = 6;
    // hw reset reads low so the block stays in reset until the pin is seen high
    localparam logic [PIN_W-1:0] PIN_RST_VAL = 7'h_30;
    localparam logic [0:0] TGL_RST_VAL = 1'h_0;

    // ==========================================================
    // control states, gray along init -> run -> hold -> run
    typedef enum logic [1:0]
    {
        DSC_ST_INIT = 2'h_0,
        DSC_ST_RUN = 2'h_1,
        DSC_ST_HOLD = 2'h_3
    } dsc_state_t;

    // ==========================================================
    // helpers
    function automatic logic [DATA_W-1:0] dsc_reset_code(input logic high_sel);
        dsc_reset_code = high_sel ? RESET_CODE_HIGH : RESET_CODE_LOW;
    endfunction

    // straight binary passes through; two's complement becomes offset binary
    function automatic logic [DATA_W-1:0] dsc_to_code(input logic [DATA_W-1:0] word,
                                                      input logic straight);
        dsc_to_code = straight ? word : (word ^ TWOS_FLIP_MASK);
    endfunction

endpackage

/* src/dsc_sync.sv */
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/100ps

module dsc_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // state
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // ==========================================================
    // next values
    // the first stage feeds only the second stage
    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;

endmodule

/* src/dsc_top.sv */
// digital control of a serially loaded 16-bit voltage-output converter
`timescale 1ns/100ps

// Functional notes
// R1: after reset, data register loads 8000h if reset-code strap high, else 0000h.
// R2: format strap high means straight binary words, low means two's complement.
// R3: hardware reset pin low resets logic and reloads the strap-chosen code.
// R4: power-down input high keeps the analog output disconnected and grounded.
// R5: serial bits shift in only while select is low; host holds select low.
// R6: serial data output is released whenever select is high.
// R7: readback strap high shifts the existing input register out on serial output.
// R8: readback strap low shifts the input shift register out, for cascading.
// R9: load input low makes the converter latch follow the input register.
// R10: one 16-bit word per transfer, msb first, captured when select rises.
module dsc_top
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic hw_reset_n,
    input wire logic reset_code_select,
    input wire logic data_format_select,
    input wire logic readback_source_select,
    input wire logic power_down_in,
    input wire logic latch_load_n,
    output logic [dsc_pkg::DATA_W-1:0] dac_code,
    output logic vout_power_down,
    output logic [dsc_pkg::DATA_W-1:0] input_word,
    output logic word_captured
);

    // ==========================================================
    // link domain state (serial clock)
    logic [dsc_pkg::DATA_W-1:0] shift_ff;
    logic [dsc_pkg::DATA_W-1:0] nxt_shift;
    logic [dsc_pkg::CNT_W-1:0] bit_cnt_ff;
    logic [dsc_pkg::CNT_W-1:0] nxt_bit_cnt;
    logic word_tgl_ff;
    logic nxt_word_tgl;

    // ==========================================================
    // reference domain state
    logic [dsc_pkg::PIN_W-1:0] pins_raw;
    logic [dsc_pkg::PIN_W-1:0] pins_s;
    logic [0:0] word_tgl_s;
    logic rst_code_s;
    logic format_s;
    logic readback_s;
    logic pwr_down_s;
    logic load_n_s;
    logic cs_n_s;
    logic hw_rst_n_s;

    dsc_pkg::dsc_state_t state_ff;
    dsc_pkg::dsc_state_t nxt_state;

    logic [dsc_pkg::DATA_W-1:0] input_word_ff;
    logic [dsc_pkg::DATA_W-1:0] nxt_input_word;
    logic [dsc_pkg::DATA_W-1:0] dac_code_ff;
    logic [dsc_pkg::DATA_W-1:0] nxt_dac_code;
    logic word_seen_ff;
    logic nxt_word_seen;
    logic word_captured_ff;
    logic nxt_word_captured;
    logic vout_pd_ff;
    logic nxt_vout_pd;
    logic cs_prev_ff;
    logic nxt_cs_prev;
    logic tgl_prev_ff;
    logic nxt_tgl_prev;

    logic word_evt;
    logic cs_rise;
    logic loading;
    logic capture;

    // ==========================================================
    // link side: shift register
    // the serial clock may stop between frames, so nothing here waits
    // for an edge after the last bit of a frame
    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_word_tgl = word_tgl_ff;
        nxt_bit_cnt = bit_cnt_ff;
        if (!spi_cs_n) // see R5
        begin
            nxt_shift = {shift_ff[dsc_pkg::DATA_W-2:0], spi_sdi}; // see R10
            nxt_bit_cnt = bit_cnt_ff + 4'h_1;
            if (bit_cnt_ff == dsc_pkg::LAST_BIT)
            begin
                nxt_word_tgl = ~word_tgl_ff; // see R10
            end
        end
    end

    always_ff @(posedge spi_sclk or posedge rst)
    begin
        if (rst)
        begin
            shift_ff <= dsc_pkg::RESET_CODE_LOW;
            word_tgl_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            word_tgl_ff <= nxt_word_tgl;
        end
    end

    // the frame's own select ends the bit count, no trailing edge needed
    always_ff @(posedge spi_sclk or posedge rst or posedge spi_cs_n)
    begin
        if (rst || spi_cs_n)
        begin
            bit_cnt_ff <= '0;
        end
        else
        begin
            bit_cnt_ff <= nxt_bit_cnt;
        end
    end

    // ==========================================================
    // link side: serial output
    // host samples on the rising edge the bit presented since the previous one
    // standalone readback indexes the input register, which outside hardware reset only changes
    // after select has risen and so is steady throughout a frame
    always_comb
    begin
        if (readback_s)
        begin
            spi_sdo = input_word_ff[~bit_cnt_ff]; // see R7
        end
        else
        begin
            spi_sdo = shift_ff[dsc_pkg::DATA_W-1]; // see R8
        end
    end

    assign spi_sdo_oe = ~spi_cs_n; // see R6

    // ==========================================================
    // pin synchronisers
    assign pins_raw[dsc_pkg::PIN_RST_CODE] = reset_code_select;
    assign pins_raw[dsc_pkg::PIN_FORMAT] = data_format_select;
    assign pins_raw[dsc_pkg::PIN_READBACK] = readback_source_select;
    assign pins_raw[dsc_pkg::PIN_PWR_DOWN] = power_down_in;
    assign pins_raw[dsc_pkg::PIN_LOAD_N] = latch_load_n;
    assign pins_raw[dsc_pkg::PIN_CS_N] = spi_cs_n;
    assign pins_raw[dsc_pkg::PIN_HW_RST_N] = hw_reset_n;

    dsc_sync
    #(
        .WIDTH(dsc_pkg::PIN_W),
        .RST_VAL(dsc_pkg::PIN_RST_VAL)
    )
    u_pin_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // word-complete event crosses as a toggle
    dsc_sync
    #(
        .WIDTH(1),
        .RST_VAL(dsc_pkg::TGL_RST_VAL)
    )
    u_tgl_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(word_tgl_ff),
        .sync_out(word_tgl_s)
    );

    assign rst_code_s = pins_s[dsc_pkg::PIN_RST_CODE];
    assign format_s = pins_s[dsc_pkg::PIN_FORMAT];
    assign readback_s = pins_s[dsc_pkg::PIN_READBACK];
    assign pwr_down_s = pins_s[dsc_pkg::PIN_PWR_DOWN];
    assign load_n_s = pins_s[dsc_pkg::PIN_LOAD_N];
    assign cs_n_s = pins_s[dsc_pkg::PIN_CS_N];
    assign hw_rst_n_s = pins_s[dsc_pkg::PIN_HW_RST_N];

    // ==========================================================
    // reset sequencing
    // straps cannot be taken by the async reset, so every clocked cycle
    // reloads the code until the synchronised hw reset pin reads high
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            dsc_pkg::DSC_ST_INIT:
            begin
                if (hw_rst_n_s)
                begin
                    nxt_state = dsc_pkg::DSC_ST_RUN;
                end
                else
                begin
                    nxt_state = dsc_pkg::DSC_ST_HOLD;
                end
            end
            dsc_pkg::DSC_ST_RUN:
            begin
                if (!hw_rst_n_s) // see R3
                begin
                    nxt_state = dsc_pkg::DSC_ST_HOLD;
                end
            end
            dsc_pkg::DSC_ST_HOLD:
            begin
                if (hw_rst_n_s)
                begin
                    nxt_state = dsc_pkg::DSC_ST_RUN;
                end
            end
            default:
            begin
                nxt_state = dsc_pkg::DSC_ST_INIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= dsc_pkg::DSC_ST_INIT;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // data path: capture, latch and power-down
    assign word_evt = word_tgl_s[0] ^ tgl_prev_ff;
    assign cs_rise = cs_n_s & ~cs_prev_ff;
    assign loading = (state_ff != dsc_pkg::DSC_ST_RUN);
    // a word completing in the same cycle as the select edge still counts
    assign capture = cs_rise & (word_seen_ff | word_evt);

    always_comb
    begin
        nxt_cs_prev = cs_n_s;
        nxt_tgl_prev = word_tgl_s[0];
        nxt_vout_pd = pwr_down_s; // see R4
        nxt_word_captured = 1'b0;
        nxt_word_seen = word_seen_ff | word_evt;
        nxt_input_word = input_word_ff;
        nxt_dac_code = dac_code_ff;
        if (loading)
        begin
            // reset code goes straight to the latch as the output code
            nxt_input_word = dsc_pkg::dsc_reset_code(rst_code_s); // see R1
            nxt_dac_code = dsc_pkg::dsc_reset_code(rst_code_s); // see R3
            nxt_word_seen = 1'b0;
        end
        else
        begin
            if (capture)
            begin
                // shift register is idle once select is high
                nxt_input_word = shift_ff; // see R10
                nxt_word_captured = 1'b1;
                nxt_word_seen = 1'b0;
            end
            if (!load_n_s)
            begin
                nxt_dac_code = dsc_pkg::dsc_to_code(nxt_input_word, format_s); // see R9 R2
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cs_prev_ff <= 1'b1;
            tgl_prev_ff <= 1'b0;
            vout_pd_ff <= 1'b0;
            word_captured_ff <= 1'b0;
            word_seen_ff <= 1'b0;
            input_word_ff <= dsc_pkg::RESET_CODE_LOW;
            dac_code_ff <= dsc_pkg::RESET_CODE_LOW;
        end
        else
        begin
            cs_prev_ff <= nxt_cs_prev;
            tgl_prev_ff <= nxt_tgl_prev;
            vout_pd_ff <= nxt_vout_pd;
            word_captured_ff <= nxt_word_captured;
            word_seen_ff <= nxt_word_seen;
            input_word_ff <= nxt_input_word;
            dac_code_ff <= nxt_dac_code;
        end
    end

    // ==========================================================
    // outputs
    assign dac_code = dac_code_ff;
    assign vout_power_down = vout_pd_ff;
    assign input_word = input_word_ff;
    assign word_captured = word_captured_ff;

endmodule

/* verif/dsc_props.sv */
// concurrent property checker for the converter control ports
`timescale 1ns/100ps

module dsc_props
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_sdo_oe,
    input wire logic hw_reset_n,
    input wire logic reset_code_select,
    input wire logic data_format_select,
    input wire logic power_down_in,
    input wire logic latch_load_n,
    input wire logic [dsc_pkg::DATA_W-1:0] dac_code,
    input wire logic vout_power_down,
    input wire logic [dsc_pkg::DATA_W-1:0] input_word,
    input wire logic word_captured
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // assertions
    chk_oe_follows_cs: assert property (spi_sdo_oe == !spi_cs_n)
        else $error("serial output enable does not follow select");
    chk_pulse_single: assert property (word_captured |=> !word_captured)
        else $error("capture pulse longer than one cycle");
    chk_cap_cs_high: assert property (word_captured |-> spi_cs_n && $past(spi_cs_n))
        else $error("word captured while select low");
    chk_cap_not_early: assert property ($rose(spi_cs_n) |-> (!word_captured)[*2])
        else $error("capture before select rise crossed");
    // straps must settle through the synchronisers before the codes are judged
    chk_hw_reset_code: assert property (($stable(reset_code_select) && !hw_reset_n)[*5] |->
        dac_code == (reset_code_select ? 16'h_8000 : 16'h_0000) && input_word == dac_code)
        else $error("hardware reset code wrong");
    chk_pd_follow: assert property (($stable(power_down_in))[*4] |->
        vout_power_down == power_down_in)
        else $error("power-down output does not follow input");
    chk_latch_follow: assert property ((!latch_load_n && hw_reset_n &&
        $stable(data_format_select))[*7] |->
        dac_code == (data_format_select ? input_word : input_word ^ 16'h_8000))
        else $error("transparent latch does not follow input register");
    chk_latch_hold: assert property ((latch_load_n && hw_reset_n)[*6] |-> $stable(dac_code))
        else $error("latch changed while load high");

    // ==========================================================
    // covers
    cov_cap_load: cover property (word_captured && !latch_load_n);
    cov_pd: cover property (vout_power_down);
    cov_hw_rst: cover property (!hw_reset_n ##5 hw_reset_n);
endmodule

/* verif/dsc_host.sv */
// serial host model driving the converter link
`timescale 1ns/100ps

module dsc_host
(
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic sdo_line
);
    logic [31:0] rx;

    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b1;
        rx = 32'h_0000_0000;
    end

    // ==========================================================
    // one frame of n bits, msb first; clock still outside frames
    task automatic xfer(input logic [31:0] w, input int n);
        #3;
        spi_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            spi_sdi = w[i];
            #6;
            rx = {rx[30:0], sdo_line};
            spi_sclk = 1'b1;
            #6;
            spi_sclk = 1'b0;
        end
        #6;
        spi_cs_n = 1'b1;
        // released data line must not look like a held bit
        spi_sdi = ~spi_sdi;
    endtask

    // ==========================================================
    // stray clock edges with select high; the device must ignore them
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            spi_sdi = i[0];
            #6;
            spi_sclk = 1'b1;
            #6;
            spi_sclk = 1'b0;
        end
    endtask
endmodule

/* verif/dsc_top_test.sv */
// self-checking bench for the converter control logic
`timescale 1ns/100ps

module dsc_top_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_n = 1'b1, reset_code_select = 1'b0, data_format_select = 1'b1;
    logic readback_source_select = 1'b1, power_down_in = 1'b0, latch_load_n = 1'b0;
    wire logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, sdo_line;
    wire logic vout_power_down, word_captured;
    wire logic [dsc_pkg::DATA_W-1:0] dac_code, input_word;
    int err_count = 0, samples_checked = 0, caps = 0, cycles = 0;

    always #5 ref_clk = ~ref_clk;
    assign sdo_line = spi_sdo_oe ? spi_sdo : 1'bz;

    dsc_top dsc_top_inst (.ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .hw_reset_n(hw_reset_n), .reset_code_select(reset_code_select),
        .data_format_select(data_format_select), .power_down_in(power_down_in),
        .readback_source_select(readback_source_select), .latch_load_n(latch_load_n),
        .dac_code(dac_code), .vout_power_down(vout_power_down), .input_word(input_word),
        .word_captured(word_captured));
    dsc_host dsc_host_inst (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .sdo_line(sdo_line));

    // counted mid-cycle so the one-cycle capture pulse is seen settled
    always @(negedge ref_clk)
    begin
        cycles++;
        if (word_captured === 1'b1)
            caps++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic send(input logic [31:0] w, input int n);
        int c0;
        c0 = caps;
        dsc_host_inst.xfer(w, n);
        cyc(8);
        chk(caps - c0, (n >= 16) ? 1 : 0);
        chk(sdo_line, 1'bz);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        for (int s = 0; s < 2; s++)
        begin
            reset_code_select = s[0];
            rst = 1'b1;
            cyc(4);
            rst = 1'b0;
            cyc(6);
            chk(dac_code, s ? 16'h_8000 : 16'h_0000);
            send(32'h_0000_1234, 16);
            hw_reset_n = 1'b0;
            cyc(6);
            chk(input_word, s ? 16'h_8000 : 16'h_0000);
            hw_reset_n = 1'b1;
            cyc(6);
        end
        $display("test reset done");
    endtask
    task automatic t_write();
        for (int f = 0; f < 2; f++)
        begin
            data_format_select = f[0];
            cyc(4);
            send(32'h_0000_a5c3, 16);
            chk(input_word, 16'h_a5c3);
            chk(dac_code, f ? 16'h_a5c3 : 16'h_25c3);
        end
        latch_load_n = 1'b1;
        send(32'h_0000_0f0f, 16);
        chk(dac_code, 16'h_a5c3);
        latch_load_n = 1'b0;
        cyc(5);
        chk(dac_code, 16'h_0f0f);
        send(32'h_0000_7fff, 15);
        chk(input_word, 16'h_0f0f);
        $display("test write done");
    endtask
    task automatic t_readback();
        send(32'h_0000_1357, 16);
        chk(dsc_host_inst.rx[15:0], 16'h_0f0f);
        readback_source_select = 1'b0;
        cyc(4);
        send(32'h_2468_9bdf, 32);
        chk(dsc_host_inst.rx, 32'h_1357_2468);
        chk(input_word, 16'h_9bdf);
        dsc_host_inst.idle_clocks(16);
        send(32'h_0000_0000, 16);
        chk(dsc_host_inst.rx[15:0], 16'h_9bdf);
        power_down_in = 1'b1;
        cyc(5);
        chk(vout_power_down, 1'b1);
        power_down_in = 1'b0;
        cyc(5);
        chk(vout_power_down, 1'b0);
        $display("test readback and power-down done");
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        cyc(4);
        rst = 1'b0;
        cyc(6);
        t_reset();
        t_write();
        t_readback();
        conclude();
    end
endmodule

bind dsc_top dsc_props dsc_props_inst (.ref_clk(ref_clk), .rst(rst), .spi_cs_n(spi_cs_n),
    .spi_sdo_oe(spi_sdo_oe), .hw_reset_n(hw_reset_n), .reset_code_select(reset_code_select),
    .data_format_select(data_format_select), .power_down_in(power_down_in),
    .latch_load_n(latch_load_n), .dac_code(dac_code), .vout_power_down(vout_power_down),
    .input_word(input_word), .word_captured(word_captured));
